// [dv/output_on_off_command_control_test.sv]
`timescale 1ns/10ps
`default_nettype none
module output_on_off_command_control_test;
  logic       clock;
  logic       rst_n;
  logic       ctrl_pin;
  logic       cmd_valid;
  logic       cmd_write;
  logic [7:0] cmd_code;
  logic [7:0] cmd_data;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic       cmd_error;
  logic       out_run;
  logic       off_immediate;
  logic       off_soft;
  logic [1:0] margin_sel;
  logic       fault_ignore;
  logic       clear_faults;
  int         n_mismatch;
  int         num_checks;
  output_on_off_command_control uut
  (
    .clock(clock),
    .rst_n(rst_n),
    .ctrl_pin(ctrl_pin),
    .cmd_valid(cmd_valid),
    .cmd_write(cmd_write),
    .cmd_code(cmd_code),
    .cmd_data(cmd_data),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .cmd_error(cmd_error),
    .out_run(out_run),
    .off_immediate(off_immediate),
    .off_soft(off_soft),
    .margin_sel(margin_sel),
    .fault_ignore(fault_ignore),
    .clear_faults(clear_faults)
  );
  pmbus_host_model host
  (
    .clock(clock),
    .ctrl_pin(ctrl_pin),
    .cmd_valid(cmd_valid),
    .cmd_write(cmd_write),
    .cmd_code(cmd_code),
    .cmd_data(cmd_data)
  );
  always #2 clock = ~clock;
  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", s, e, g);
      n_mismatch++;
    end
  endtask
  task automatic wr(input logic [7:0] c, d, input logic e);
    host.send(1'b1, c, d);
    chk("cmd_error", 8'(e), 8'(cmd_error));
  endtask
  task automatic rd(input logic [7:0] c, e);
    host.send(1'b0, c, 8'h00);
    chk("rd_valid", 8'h01, 8'(rd_valid));
    chk("rd_data", e, rd_data);
  endtask
  // the off pulses live only in the cycle out_run falls, so poll
  // each cycle instead of waiting a fixed time
  task automatic run(input logic e, i, s);
    int n;
    n = 0;
    while (out_run !== e && n < 8)
    begin
      @(negedge clock);
      n++;
    end
    if (out_run !== e)
    begin
      n_mismatch++;
      finish_test();
    end
    chk("out_run", 8'(e), 8'(out_run));
    chk("off_immediate", 8'(i), 8'(off_immediate));
    chk("off_soft", 8'(s), 8'(off_soft));
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_powerup();
    rd(8'h01, 8'h48);
    rd(8'h02, 8'h1C);
    run(1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_bus();
    host.set_pin(1'b1);
    repeat (4) @(negedge clock);
    run(1'b0, 1'b0, 1'b0);
    wr(8'h01, 8'h88, 1'b0);
    run(1'b1, 1'b0, 1'b0);
    wr(8'h01, 8'h08, 1'b0);
    run(1'b0, 1'b1, 1'b0);
    wr(8'h01, 8'h88, 1'b0);
    run(1'b1, 1'b0, 1'b0);
    wr(8'h01, 8'h48, 1'b0);
    run(1'b0, 1'b0, 1'b1);
  endtask
  task automatic t_margin();
    logic [7:0] op [3] = '{8'h98, 8'hA4, 8'h84};
    logic [1:0] mg [3] = '{2'h1, 2'h2, 2'h0};
    logic [2:0] fi = 3'b010;
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h01, op[k], 1'b0);
      @(negedge clock);
      chk("margin_sel", 8'(mg[k]), 8'(margin_sel));
      chk("fault_ignore", 8'(fi[k]), 8'(fault_ignore));
    end
  endtask
  task automatic t_invalid();
    logic [7:0] bad [4] = '{8'hC8, 8'hB8, 8'h80, 8'h8C};
    for (int k = 0; k < 4; k++)
      wr(8'h01, bad[k], 1'b1);
    rd(8'h01, 8'h84);
  endtask
  task automatic t_pin();
    wr(8'h02, 8'h1E, 1'b0);
    run(1'b0, 1'b0, 1'b1);
    host.set_pin(1'b0);
    run(1'b1, 1'b0, 1'b0);
    wr(8'h02, 8'h1F, 1'b0);
    host.set_pin(1'b1);
    run(1'b0, 1'b1, 1'b0);
  endtask
  task automatic t_sources();
    wr(8'h01, 8'h48, 1'b0);
    wr(8'h02, 8'h14, 1'b0);
    run(1'b1, 1'b0, 1'b0);
    host.set_pin(1'b0);
    run(1'b0, 1'b0, 1'b1);
    wr(8'h02, 8'h0C, 1'b0);
    run(1'b1, 1'b0, 1'b0);
    wr(8'h02, 8'h18, 1'b0);
    run(1'b0, 1'b0, 1'b1);
    wr(8'h01, 8'h88, 1'b0);
    run(1'b1, 1'b0, 1'b0);
  endtask
  task automatic t_store();
    wr(8'h01, 8'h98, 1'b0);
    wr(8'h15, 8'h00, 1'b0);
    wr(8'h01, 8'h88, 1'b0);
    wr(8'h16, 8'h00, 1'b0);
    rd(8'h01, 8'h98);
    wr(8'h12, 8'h00, 1'b0);
    rd(8'h01, 8'h48);
    rd(8'h02, 8'h1C);
    // only the on/off setting is dirty now; the stored operation stays
    wr(8'h02, 8'h1E, 1'b0);
    wr(8'h15, 8'h00, 1'b0);
    wr(8'h16, 8'h00, 1'b0);
    rd(8'h01, 8'h98);
    rd(8'h02, 8'h1E);
  endtask
  task automatic t_misc();
    wr(8'h03, 8'h00, 1'b0);
    chk("clear_faults", 8'h01, 8'(clear_faults));
    host.send(1'b1, 8'h19, 8'h00);
    chk("cmd_error", 8'h01, 8'(cmd_error));
    host.send(1'b0, 8'h03, 8'h00);
    chk("cmd_error", 8'h01, 8'(cmd_error));
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    // first edge after release belongs to the automatic restore
    @(negedge clock);
    t_powerup();
    t_bus();
    t_margin();
    t_invalid();
    t_pin();
    t_sources();
    t_store();
    t_misc();
    finish_test();
  end
endmodule
`default_nettype wire

// [dv/pmbus_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pmbus_host_model
(
  input  wire logic       clock,
  output var  logic       ctrl_pin,
  output var  logic       cmd_valid,
  output var  logic       cmd_write,
  output var  logic [7:0] cmd_code,
  output var  logic [7:0] cmd_data
);
  initial
  begin
    ctrl_pin = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_data = 8'h00;
  end
  ////////////////////////////////////////////////////////////
  // one command per call; fields invert once released so a
  // stale value can never pass for a fresh command
  task automatic send(input logic w, input logic [7:0] c, d);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_data = d;
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_write = ~w;
    cmd_code = ~c;
    cmd_data = ~d;
  endtask
  task automatic set_pin(input logic v);
    @(negedge clock);
    ctrl_pin = v;
  endtask
endmodule
`default_nettype wire

// [hw/on_off_pkg.sv]
package on_off_pkg;
  // command codes
  localparam logic [7:0] CODE_OPERATION   = 8'h01;
  localparam logic [7:0] CODE_ON_OFF_CFG  = 8'h02;
  localparam logic [7:0] CODE_CLEAR_FAULT = 8'h03;
  localparam logic [7:0] CODE_RESTORE_DEF = 8'h12;
  localparam logic [7:0] CODE_STORE_USER  = 8'h15;
  localparam logic [7:0] CODE_RESTORE_USR = 8'h16;
  // operation field positions
  localparam int OP_EN_HI  = 7;
  localparam int OP_EN_LO  = 6;
  localparam int OP_MG_HI  = 5;
  localparam int OP_MG_LO  = 4;
  localparam int OP_ACT_HI = 3;
  localparam int OP_ACT_LO = 2;
  // operation field encodings
  localparam logic [1:0] EN_IMM_OFF  = 2'h0;
  localparam logic [1:0] EN_SOFT_OFF = 2'h1;
  localparam logic [1:0] EN_RUN      = 2'h2;
  localparam logic [1:0] MG_NOMINAL  = 2'h0;
  localparam logic [1:0] MG_LOW      = 2'h1;
  localparam logic [1:0] MG_HIGH     = 2'h2;
  localparam logic [1:0] ACT_IGNORE  = 2'h1;
  localparam logic [1:0] ACT_HANDLE  = 2'h2;
  // on/off configuration bit positions
  localparam int CFG_POWERUP  = 4;
  localparam int CFG_BUS_MODE = 3;
  localparam int CFG_PIN_MODE = 2;
  localparam int CFG_PIN_POL  = 1;
  localparam int CFG_PIN_IMM  = 0;
  // factory default store contents; read data reset value
  localparam logic [7:0] DEF_OPERATION = 8'h48;
  localparam logic [7:0] DEF_ON_OFF    = 8'h1C;
  localparam logic [7:0] RESET_ZERO    = 8'h00;
  typedef enum logic [1:0]
  {
    ST_RESTORE = 2'b00,
    ST_OFF     = 2'b01,
    ST_ON      = 2'b10
  } run_state_t;
endpackage

// [hw/output_on_off_command_control.sv]
`timescale 1ns/10ps
`default_nettype none
module output_on_off_command_control
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       ctrl_pin,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_write,
  input  wire logic [7:0] cmd_code,
  input  wire logic [7:0] cmd_data,
  output var  logic [7:0] rd_data,
  output var  logic       rd_valid,
  output var  logic       cmd_error,
  output var  logic       out_run,
  output var  logic       off_immediate,
  output var  logic       off_soft,
  output var  logic [1:0] margin_sel,
  output var  logic       fault_ignore,
  output var  logic       clear_faults
);

  logic [7:0] operation;
  logic [7:0] on_off_cfg;
  logic [7:0] user_op;
  logic [7:0] user_cfg;
  logic [1:0] dirty;
  on_off_pkg::run_state_t state;
  on_off_pkg::run_state_t next_state;
  logic pin_req;
  logic bus_req;
  logic run_req;
  logic off_imm_kind;
  logic wr_op;
  logic wr_cfg;
  logic do_store;
  logic do_rest_usr;
  logic do_rest_def;
  logic known;

  function automatic logic op_ok(input logic [7:0] v);
    logic [1:0] en;
    logic [1:0] mg;
    logic [1:0] act;
    en  = v[on_off_pkg::OP_EN_HI:on_off_pkg::OP_EN_LO];
    mg  = v[on_off_pkg::OP_MG_HI:on_off_pkg::OP_MG_LO];
    act = v[on_off_pkg::OP_ACT_HI:on_off_pkg::OP_ACT_LO];
    op_ok = (en != 2'h3) && (mg != 2'h3) &&
            (act == on_off_pkg::ACT_IGNORE ||
             act == on_off_pkg::ACT_HANDLE);
  endfunction

  function automatic logic is_cmd(input logic [7:0] c, input logic [7:0] k);
    is_cmd = cmd_valid && cmd_write && (c == k);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  assign wr_op       = is_cmd(cmd_code, on_off_pkg::CODE_OPERATION) &&
                       op_ok(cmd_data);
  assign wr_cfg      = is_cmd(cmd_code, on_off_pkg::CODE_ON_OFF_CFG);
  assign do_store    = is_cmd(cmd_code, on_off_pkg::CODE_STORE_USER);
  assign do_rest_usr = is_cmd(cmd_code, on_off_pkg::CODE_RESTORE_USR) ||
                       (state == on_off_pkg::ST_RESTORE);
  assign do_rest_def = is_cmd(cmd_code, on_off_pkg::CODE_RESTORE_DEF);
  assign known = (cmd_code == on_off_pkg::CODE_OPERATION) ||
                 (cmd_code == on_off_pkg::CODE_ON_OFF_CFG) ||
                 (cmd_write && (cmd_code == on_off_pkg::CODE_CLEAR_FAULT ||
                                cmd_code == on_off_pkg::CODE_RESTORE_DEF ||
                                cmd_code == on_off_pkg::CODE_STORE_USER ||
                                cmd_code == on_off_pkg::CODE_RESTORE_USR));

  ////////////////////////////////////////////////////////////////////////////
  // live configuration; a restore outranks a same-cycle write

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      operation  <= on_off_pkg::DEF_OPERATION;
      on_off_cfg <= on_off_pkg::DEF_ON_OFF;
    end
    else if (do_rest_def)
    begin
      operation  <= on_off_pkg::DEF_OPERATION;
      on_off_cfg <= on_off_pkg::DEF_ON_OFF;
    end
    else if (do_rest_usr)
    begin
      operation  <= user_op;
      on_off_cfg <= user_cfg;
    end
    else
    begin
      if (wr_op)
        operation <= cmd_data;
      if (wr_cfg)
        on_off_cfg <= cmd_data;
    end
  end

  // only registers written since the last restore or store are saved
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      dirty <= 2'h0;
    else if (do_rest_def || do_rest_usr || do_store)
      dirty <= 2'h0;
    else
      dirty <= dirty | {wr_cfg, wr_op};
  end

  // user store is volatile here; it starts at factory values
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      user_op  <= on_off_pkg::DEF_OPERATION;
      user_cfg <= on_off_pkg::DEF_ON_OFF;
    end
    else if (do_store)
    begin
      if (dirty[0])
        user_op <= operation;
      if (dirty[1])
        user_cfg <= on_off_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back and command status
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data   <= on_off_pkg::RESET_ZERO;
      rd_valid  <= 1'b0;
      cmd_error <= 1'b0;
    end
    else
    begin
      rd_valid  <= cmd_valid && !cmd_write && known;
      cmd_error <= cmd_valid && (!known ||
                   (cmd_write && cmd_code == on_off_pkg::CODE_OPERATION &&
                    !op_ok(cmd_data)));
      if (cmd_valid && !cmd_write && cmd_code == on_off_pkg::CODE_OPERATION)
        rd_data <= operation;
      else if (cmd_valid && !cmd_write && known)
        rd_data <= on_off_cfg;
      else
        rd_data <= on_off_pkg::RESET_ZERO;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      clear_faults <= 1'b0;
    else
      clear_faults <= is_cmd(cmd_code, on_off_pkg::CODE_CLEAR_FAULT);
  end

  ////////////////////////////////////////////////////////////////////////////
  // run decision
  assign pin_req = !on_off_cfg[on_off_pkg::CFG_PIN_MODE] ||
                   (ctrl_pin ^ on_off_cfg[on_off_pkg::CFG_PIN_POL]);
  assign bus_req = !on_off_cfg[on_off_pkg::CFG_BUS_MODE] ||
                   (operation[on_off_pkg::OP_EN_HI:on_off_pkg::OP_EN_LO] ==
                    on_off_pkg::EN_RUN);
  assign run_req = !on_off_cfg[on_off_pkg::CFG_POWERUP] ||
                   (pin_req && bus_req);
  // a bus order for immediate off or a pin with fast action wins over soft
  assign off_imm_kind =
    (!bus_req && operation[on_off_pkg::OP_EN_HI:on_off_pkg::OP_EN_LO] ==
     on_off_pkg::EN_IMM_OFF) ||
    (!pin_req && on_off_cfg[on_off_pkg::CFG_PIN_IMM]);

  always_comb
  begin
    next_state = state;
    case (state)
      on_off_pkg::ST_RESTORE: next_state = on_off_pkg::ST_OFF;
      on_off_pkg::ST_OFF:
        if (run_req)
          next_state = on_off_pkg::ST_ON;
      on_off_pkg::ST_ON:
        if (!run_req)
          next_state = on_off_pkg::ST_OFF;
      default: next_state = on_off_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state         <= on_off_pkg::ST_RESTORE;
      out_run       <= 1'b0;
      off_immediate <= 1'b0;
      off_soft      <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      out_run       <= next_state == on_off_pkg::ST_ON;
      off_immediate <= (state == on_off_pkg::ST_ON) && !run_req &&
                       off_imm_kind;
      off_soft      <= (state == on_off_pkg::ST_ON) && !run_req &&
                       !off_imm_kind;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      margin_sel   <= on_off_pkg::MG_NOMINAL;
      fault_ignore <= 1'b0;
    end
    else
    begin
      margin_sel   <= operation[on_off_pkg::OP_MG_HI:on_off_pkg::OP_MG_LO];
      fault_ignore <=
        (operation[on_off_pkg::OP_MG_HI:on_off_pkg::OP_MG_LO] !=
         on_off_pkg::MG_NOMINAL) &&
        (operation[on_off_pkg::OP_ACT_HI:on_off_pkg::OP_ACT_LO] ==
         on_off_pkg::ACT_IGNORE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_always_on;
    @(posedge clock) disable iff (!rst_n)
    (state != on_off_pkg::ST_RESTORE) &&
    !on_off_cfg[on_off_pkg::CFG_POWERUP] |=> out_run;
  endproperty
  a_always_on: assert property (p_always_on)
    else $error("unit not running with powerup bit clear");

  property p_pin_gate;
    @(posedge clock) disable iff (!rst_n)
    on_off_cfg[on_off_pkg::CFG_POWERUP] && on_off_cfg[on_off_pkg::CFG_PIN_MODE]
    && (ctrl_pin == on_off_cfg[on_off_pkg::CFG_PIN_POL]) |=> !out_run;
  endproperty
  a_pin_gate: assert property (p_pin_gate)
    else $error("ran with control pin deasserted");

  property p_bus_gate;
    @(posedge clock) disable iff (!rst_n)
    on_off_cfg[on_off_pkg::CFG_POWERUP] && on_off_cfg[on_off_pkg::CFG_BUS_MODE]
    && operation[7:6] != on_off_pkg::EN_RUN |=> !out_run;
  endproperty
  a_bus_gate: assert property (p_bus_gate)
    else $error("ran without bus run order");

  property p_bus_ignored;
    @(posedge clock) disable iff (!rst_n)
    (state != on_off_pkg::ST_RESTORE) && on_off_cfg[4:2] == 3'h4 |=> out_run;
  endproperty
  a_bus_ignored: assert property (p_bus_ignored)
    else $error("bus order honoured while bus mode off");

  property p_imm_off;
    @(posedge clock) disable iff (!rst_n)
    out_run && on_off_cfg[4:3] == 2'h3 &&
    operation[7:6] == on_off_pkg::EN_IMM_OFF |=> off_immediate && !out_run;
  endproperty
  a_imm_off: assert property (p_imm_off)
    else $error("immediate off not taken");

  property p_soft_off;
    @(posedge clock) disable iff (!rst_n)
    out_run && on_off_cfg[4:2] == 3'h6 &&
    operation[7:6] == on_off_pkg::EN_SOFT_OFF |=> off_soft && !off_immediate;
  endproperty
  a_soft_off: assert property (p_soft_off)
    else $error("soft off not taken");

  // back-to-back clears are legal, so the pulse may only stay up for a
  // fresh command one cycle later
  property p_clear;
    @(posedge clock) disable iff (!rst_n)
    cmd_valid && cmd_write && cmd_code == on_off_pkg::CODE_CLEAR_FAULT |=>
    clear_faults ##1
    (clear_faults == ($past(cmd_valid) && $past(cmd_write) &&
                      $past(cmd_code) == on_off_pkg::CODE_CLEAR_FAULT));
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear faults pulse wrong");
  property p_invalid;
    @(posedge clock) disable iff (!rst_n)
    cmd_valid && cmd_write && cmd_code == on_off_pkg::CODE_OPERATION &&
    !op_ok(cmd_data) && !do_rest_usr |=> $stable(operation) && cmd_error;
  endproperty
  a_invalid: assert property (p_invalid)
    else $error("invalid operation value accepted");
  property p_powerup_restore;
    @(posedge clock) disable iff (!rst_n)
    state == on_off_pkg::ST_RESTORE |=> operation == $past(user_op) &&
    state == on_off_pkg::ST_OFF;
  endproperty
  a_powerup_restore: assert property (p_powerup_restore)
    else $error("power-up restore missing");
  property p_margin_faults;
    @(posedge clock) disable iff (!rst_n)
    fault_ignore |-> margin_sel != on_off_pkg::MG_NOMINAL;
  endproperty
  a_margin_faults: assert property (p_margin_faults)
    else $error("faults ignored at nominal");

  c_run: cover property (@(posedge clock) disable iff (!rst_n) $rose(out_run));
  c_imm: cover property (@(posedge clock) disable iff (!rst_n) off_immediate);
  c_soft: cover property (@(posedge clock) disable iff (!rst_n) off_soft);
  c_store: cover property (@(posedge clock) disable iff (!rst_n)
    do_store && dirty != 2'h0);
endmodule
`default_nettype wire
